//--- inc/mmdia_pkg.sv
/*
  shared constants, field layouts and carrier types for the management
  register slice with the indirect access pair.
  assumes a 5-bit clause 22 register address and 16-bit register data.
*/
package mmdia_pkg;

  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [4:0] OFS_IDENT_HIGH = 5'h02;
  localparam logic [4:0] OFS_IDENT_LOW  = 5'h03;
  localparam logic [4:0] OFS_CONTROL    = 5'h0d;
  localparam logic [4:0] OFS_WINDOW     = 5'h0e;

  // ----------------------------------------
  // field positions and reset values
  // ----------------------------------------
  localparam int FUNC_MSB      = 15;
  localparam int FUNC_LSB      = 14;
  localparam int DEVSEL_MSB    = 4;
  localparam int DEVSEL_LSB    = 0;
  localparam int ORGLOW_LSB    = 10;
  localparam int MODEL_LSB     = 4;
  localparam int REV_LSB       = 0;
  localparam logic [15:0] CONTROL_RESET = 16'h0000;
  localparam logic [15:0] WINDOW_RESET  = 16'h0000;
  localparam logic [15:0] UNMAPPED_READ = 16'h0000;

  // ----------------------------------------
  // access functions and carriers
  // ----------------------------------------
  typedef enum logic [1:0] {
    FN_ADDRESS   = 2'h0,
    FN_DATA      = 2'h1,
    FN_DATA_INC  = 2'h2,
    FN_DATA_WINC = 2'h3
  } mmdia_func_type;

  typedef struct packed {
    logic [4:0]  addr;
    logic        write;
    logic [15:0] wdata;
  } mmdia_mgmt_req_type;

  typedef struct packed {
    logic [4:0]  devsel;
    logic [15:0] regaddr;
    logic        write;
    logic [15:0] wdata;
  } mmdia_mmd_req_type;

  function automatic logic [15:0] next_addr(input logic [15:0] a);
    next_addr = a + 16'h0001;
  endfunction : next_addr

endpackage : mmdia_pkg

//--- rtl/mmdia_addr_store.sv
/*
  per-mmd stored register address, one word per device select value.
  assumes writes come from the access port one at a time; read is combinational.
*/
`timescale 1ns/1ps
module mmdia_addr_store #(
  parameter int DEVICES = 32
) (
  input  wire logic        mclk,
  input  wire logic        rstn,
  input  wire logic        ce,
  input  wire logic        wr_en,
  input  wire logic [4:0]  sel,
  input  wire logic [15:0] wr_data,
  output logic      [15:0] rd_data
);

  // one word per five-bit device select at most
  if (DEVICES < 1 || DEVICES > 32) begin : g_bad_devices
    $error("DEVICES must be 1..32");
  end

  logic [15:0] addr_mem_q [DEVICES];
  wire         sel_ok = 32'(sel) < DEVICES;

  assign rd_data = sel_ok ? addr_mem_q[sel] : 16'h0000;

  // all stored addresses clear at reset so a fresh window access starts at zero
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < DEVICES; i++) addr_mem_q[i] <= mmdia_pkg::WINDOW_RESET;
    end else if (ce && wr_en && sel_ok) begin
      addr_mem_q[sel] <= wr_data;
    end
  end

endmodule : mmdia_addr_store

//--- rtl/mmdia_core.sv
/*
  management register slice: identifier pair plus indirect control and
  window registers that forward accesses into the mmd address space.
  assumes one management request at a time, held off while busy_q is high,
  and an mmd side that answers each forwarded access with mmd_ack.
*/
`timescale 1ns/1ps
module mmdia_core #(
  parameter logic [15:0] ORG_CODE_HIGH = 16'h1234, // arbitrary value
  parameter logic [5:0]  ORG_LOW_BITS  = 6'h15,    // arbitrary value
  parameter logic [3:0]  REVISION      = 4'h5,     // arbitrary value
  parameter int          DEVICES       = 32
) (
  input  wire logic                         mclk,
  input  wire logic                         rstn,
  input  wire logic                         ce,
  input  wire logic [5:0]                   model_strap,
  input  wire logic                         req,
  input  wire mmdia_pkg::mmdia_mgmt_req_type req_data,
  output logic                              ack_q,
  output logic      [15:0]                  rd_data_q,
  output logic                              busy_q,
  output logic                              mmd_valid_q,
  output mmdia_pkg::mmdia_mmd_req_type      mmd_req_q,
  input  wire logic                         mmd_ack,
  input  wire logic [15:0]                  mmd_rdata
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef enum logic {ST_IDLE, ST_WAIT} mmdia_state_type;

  mmdia_state_type                 state_q;
  logic            [1:0]           func_q;
  logic            [4:0]           devsel_q;
  logic            [5:0]           model_q;
  logic                            strap_taken_q;
  logic                            pend_write_q;
  mmdia_state_type                 state_d;
  logic                            busy_d;
  logic                            ack_d;
  logic            [15:0]          rd_data_d;
  logic                            mmd_valid_d;
  mmdia_pkg::mmdia_mmd_req_type    mmd_req_d;
  mmdia_pkg::mmdia_mmd_req_type    fwd_req;
  logic                            pend_write_d;

  // ----------------------------------------
  // parameter checks
  // ----------------------------------------
  // the address store holds at most one word per five-bit device select
  if (DEVICES < 1 || DEVICES > 32) begin : g_bad_devices
    $error("DEVICES must be 1..32");
  end

  // ----------------------------------------
  // control field helpers
  // ----------------------------------------
  // reset and write both slice the same fields, so the slicing lives in one place
  function automatic logic [1:0] func_field(input logic [15:0] word);
    func_field = word[mmdia_pkg::FUNC_MSB:mmdia_pkg::FUNC_LSB];
  endfunction : func_field

  function automatic logic [4:0] devsel_field(input logic [15:0] word);
    devsel_field = word[mmdia_pkg::DEVSEL_MSB:mmdia_pkg::DEVSEL_LSB];
  endfunction : devsel_field

  localparam logic [1:0] FUNC_RESET   = func_field(mmdia_pkg::CONTROL_RESET);
  localparam logic [4:0] DEVSEL_RESET = devsel_field(mmdia_pkg::CONTROL_RESET);

  // ----------------------------------------
  // decode
  // ----------------------------------------
  wire                  take      = ce && req && (state_q == ST_IDLE);
  wire                  hit_ctl   = req_data.addr == mmdia_pkg::OFS_CONTROL;
  wire                  hit_win   = req_data.addr == mmdia_pkg::OFS_WINDOW;
  wire                  fn_addr   = func_q == mmdia_pkg::FN_ADDRESS;
  wire                  fwd       = take && hit_win && !fn_addr;
  wire                  done      = ce && (state_q == ST_WAIT) && mmd_ack;
  wire                  ctl_wr    = take && hit_ctl && req_data.write;
  wire [15:0]           stored;
  wire [15:0]           ident_low = {ORG_LOW_BITS, model_q, REVISION};
  wire [15:0]           control_rd = {func_q, 9'h000, devsel_q};

  // post-increment only on function 10 (any access) or 11 (writes)
  wire                  bump      = done && ((func_q == mmdia_pkg::FN_DATA_INC)
                                  || (func_q == mmdia_pkg::FN_DATA_WINC && pend_write_q));
  wire                  addr_wr   = take && hit_win && fn_addr && req_data.write;
  wire                  store_we  = addr_wr || bump;
  wire [15:0]           store_wd  = addr_wr ? req_data.wdata : mmdia_pkg::next_addr(stored);

  logic [15:0] rd_mux;
  always_comb begin
    unique case (req_data.addr)
      mmdia_pkg::OFS_IDENT_HIGH: rd_mux = ORG_CODE_HIGH;
      mmdia_pkg::OFS_IDENT_LOW:  rd_mux = ident_low;
      mmdia_pkg::OFS_CONTROL:    rd_mux = control_rd;
      mmdia_pkg::OFS_WINDOW:     rd_mux = stored;
      default:                   rd_mux = mmdia_pkg::UNMAPPED_READ;
    endcase
  end

  // ----------------------------------------
  // stored address per mmd
  // ----------------------------------------
  mmdia_addr_store #(.DEVICES(DEVICES)) u_store (
    .mclk    (mclk),
    .rstn    (rstn),
    .ce      (ce),
    .wr_en   (store_we),
    .sel     (devsel_q),
    .wr_data (store_wd),
    .rd_data (stored)
  );

  // ----------------------------------------
  // strap capture
  // ----------------------------------------
  // taken on the first enabled edge after reset release, never under reset;
  // a strap change after that is only seen after the next reset
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      strap_taken_q <= 1'b0;
      model_q       <= 6'h00;
    end else if (ce && !strap_taken_q) begin
      strap_taken_q <= 1'b1;
      model_q       <= model_strap;
    end
  end

  // ----------------------------------------
  // control register
  // ----------------------------------------
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      func_q   <= FUNC_RESET;
      devsel_q <= DEVSEL_RESET;
    end else if (ctl_wr) begin
      func_q   <= func_field(req_data.wdata);
      devsel_q <= devsel_field(req_data.wdata);
    end
  end

  // ----------------------------------------
  // access sequencing
  // ----------------------------------------
  // id registers ignore writes; data-mode window accesses wait for the mmd.
  // next values are plain selections so every register block below stays flat
  wire                  local_ans = take && !fwd;
  wire                  local_rd  = local_ans && !req_data.write;
  wire                  mmd_rd    = done && !pend_write_q;

  assign fwd_req      = '{devsel:  devsel_q,
                          regaddr: stored,
                          write:   req_data.write,
                          wdata:   req_data.wdata};
  assign state_d      = fwd ? ST_WAIT : (done ? ST_IDLE : state_q);
  assign busy_d       = fwd || (busy_q && !done);
  assign ack_d        = local_ans || done;
  assign rd_data_d    = local_rd ? rd_mux : (mmd_rd ? mmd_rdata :
                        ((local_ans || done) ? 16'h0000 : rd_data_q));
  assign mmd_valid_d  = fwd;
  assign mmd_req_d    = fwd ? fwd_req : mmd_req_q;
  assign pend_write_d = fwd ? req_data.write : pend_write_q;

  // ----------------------------------------
  // sequencing registers
  // ----------------------------------------
  // busy_q mirrors the wait state so the master sees the hold-off without decoding state
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_q <= ST_IDLE;
      busy_q  <= 1'b0;
    end else if (ce) begin
      state_q <= state_d;
      busy_q  <= busy_d;
    end
  end

  // answer pulses last one enabled cycle; a low ce stretches them
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ack_q       <= 1'b0;
      mmd_valid_q <= 1'b0;
    end else if (ce) begin
      ack_q       <= ack_d;
      mmd_valid_q <= mmd_valid_d;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rd_data_q <= 16'h0000;
    end else if (ce) begin
      rd_data_q <= rd_data_d;
    end
  end

  // the forwarded request stands until the next forward so the mmd may sample it late
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      mmd_req_q    <= '0;
      pend_write_q <= 1'b0;
    end else if (ce) begin
      mmd_req_q    <= mmd_req_d;
      pend_write_q <= pend_write_d;
    end
  end

endmodule : mmdia_core

//--- bench/mmdia_core_properties.sv
/* port assertions for the register slice core.
   assumes it is bound into every mmdia_core instance. */
`timescale 1ns/1ps
module mmdia_core_properties #(
  parameter logic [15:0] ORG_CODE_HIGH = 16'h1234,
  parameter logic [5:0]  ORG_LOW_BITS  = 6'h15,
  parameter logic [3:0]  REVISION      = 4'h5
) (
  input wire logic                         mclk,
  input wire logic                         rstn,
  input wire logic                         ce,
  input wire logic                         req,
  input wire mmdia_pkg::mmdia_mgmt_req_type req_data,
  input wire logic                         ack_q,
  input wire logic [15:0]                  rd_data_q,
  input wire logic                         busy_q,
  input wire logic                         mmd_valid_q,
  input wire mmdia_pkg::mmdia_mmd_req_type  mmd_req_q,
  input wire logic                         mmd_ack,
  input wire logic [15:0]                  mmd_rdata
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  wire tk = ce && req && !busy_q;
  wire rd_tk = tk && !req_data.write;
  wire local_tk = tk && (req_data.addr != mmdia_pkg::OFS_WINDOW);
  ident_high_a: assert property (rd_tk && req_data.addr == mmdia_pkg::OFS_IDENT_HIGH
    |=> ack_q && rd_data_q == ORG_CODE_HIGH) else $error("ident high read wrong");
  ident_low_a: assert property (rd_tk && req_data.addr == mmdia_pkg::OFS_IDENT_LOW
    |=> rd_data_q[15:10] == ORG_LOW_BITS && rd_data_q[3:0] == REVISION)
    else $error("ident low read wrong");
  reserved_zero_a: assert property (rd_tk && req_data.addr == mmdia_pkg::OFS_CONTROL
    |=> rd_data_q[13:5] == 9'h0) else $error("reserved control bits set");
  local_ack_a: assert property (local_tk |=> ack_q && !mmd_valid_q)
    else $error("local access not answered in one cycle");
  write_zero_a: assert property (local_tk && req_data.write |=> rd_data_q == 16'h0)
    else $error("write answer carries data");
  fwd_cause_a: assert property (mmd_valid_q && $past(ce) |-> busy_q && $past(tk)
    && $past(req_data.addr) == mmdia_pkg::OFS_WINDOW) else $error("stray indirect_window");
  mmd_answer_a: assert property (ce && busy_q && mmd_ack |=> ack_q && !busy_q
    && rd_data_q == (mmd_req_q.write ? 16'h0 : $past(mmd_rdata)))
    else $error("mmd answer not passed back");
  busy_hold_a: assert property (busy_q && !(ce && mmd_ack) |=> busy_q && !ack_q)
    else $error("busy dropped without mmd answer");
  ack_cause_a: assert property (ack_q && $past(ce) |-> $past(tk) || $past(busy_q && mmd_ack))
    else $error("answer without request");
endmodule : mmdia_core_properties

bind mmdia_core mmdia_core_properties #(.ORG_CODE_HIGH(ORG_CODE_HIGH),
  .ORG_LOW_BITS(ORG_LOW_BITS), .REVISION(REVISION)) u_props (.mclk, .rstn, .ce,
  .req, .req_data, .ack_q, .rd_data_q, .busy_q, .mmd_valid_q, .mmd_req_q, .mmd_ack,
  .mmd_rdata);

//--- bench/mmdia_mmd_model.sv
/* behavioural mmd: answers each forwarded access after one or four cycles.
   assumes one outstanding access; read data mixes devsel into the address. */
`timescale 1ns/1ps
module mmdia_mmd_model (
  input  wire logic                        mclk,
  input  wire logic                        rstn,
  input  wire logic                        slow,
  input  wire logic                        valid,
  input  wire mmdia_pkg::mmdia_mmd_req_type req,
  output logic                             ack,
  output logic      [15:0]                 rdata
);
  logic [2:0] cnt_q;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= 3'h0;
      ack <= 1'b0;
      rdata <= 16'hffff;
    end else begin
      ack <= 1'b0;
      rdata <= ~rdata; // flips between answers, so the last word shows again every other cycle
      if (valid) cnt_q <= slow ? 3'h4 : 3'h1;
      else if (cnt_q != 3'h0) cnt_q <= cnt_q - 3'h1;
      if (!valid && cnt_q == 3'h1) begin
        ack <= 1'b1;
        rdata <= req.regaddr ^ {req.devsel, 11'h0};
      end
    end
  end
endmodule : mmdia_mmd_model

//--- bench/mmdia_core_tb_top.sv
/* self-checking bench for the register slice core and its mmd port.
   assumes the bound checker and the behavioural mmd model. */
`timescale 1ns/1ps
module mmdia_core_tb_top;
  typedef struct packed {
    logic [4:0]  a;
    logic        w;
    logic [15:0] d;
    logic [15:0] e;
  } mmdia_row_type;
  logic mclk = 1'b0, rstn = 1'b0, ce = 1'b1, req = 1'b0, slow = 1'b0;
  logic [5:0] strap = 6'h2a;
  mmdia_pkg::mmdia_mgmt_req_type req_data = '0;
  mmdia_pkg::mmdia_mmd_req_type  mmd_req_q;
  logic ack_q, busy_q, mmd_valid_q, mmd_ack;
  logic [15:0] rd_data_q, mmd_rdata, rd;
  int miscompares = 0, n_tests = 0;
  mmdia_row_type rows [25] = '{
    '{5'h02, 1'b0, 16'h0000, 16'h1234}, '{5'h02, 1'b1, 16'hffff, 16'h0000},
    '{5'h02, 1'b0, 16'h0000, 16'h1234}, '{5'h03, 1'b0, 16'h0000, 16'h56a5},
    '{5'h0d, 1'b1, 16'hffff, 16'h0000}, '{5'h0d, 1'b0, 16'h0000, 16'hc01f},
    '{5'h0d, 1'b1, 16'h0003, 16'h0000}, '{5'h0e, 1'b1, 16'h0100, 16'h0000},
    '{5'h0e, 1'b0, 16'h0000, 16'h0100}, '{5'h0d, 1'b1, 16'h8003, 16'h0000},
    '{5'h0e, 1'b0, 16'h0000, 16'h1900}, '{5'h0e, 1'b0, 16'h0000, 16'h1901},
    '{5'h0e, 1'b1, 16'hbeef, 16'h0000}, '{5'h0d, 1'b1, 16'h0003, 16'h0000},
    '{5'h0e, 1'b0, 16'h0000, 16'h0103}, '{5'h0d, 1'b1, 16'hc003, 16'h0000},
    '{5'h0e, 1'b0, 16'h0000, 16'h1903}, '{5'h0e, 1'b0, 16'h0000, 16'h1903},
    '{5'h0e, 1'b1, 16'h0001, 16'h0000}, '{5'h0d, 1'b1, 16'h4003, 16'h0000},
    '{5'h0e, 1'b0, 16'h0000, 16'h1904}, '{5'h0e, 1'b0, 16'h0000, 16'h1904},
    '{5'h0d, 1'b1, 16'h0005, 16'h0000}, '{5'h0e, 1'b0, 16'h0000, 16'h0000},
    '{5'h07, 1'b0, 16'h0000, 16'h0000}};
  always #12.5 mclk = ~mclk;
  mmdia_core dut (.mclk, .rstn, .ce, .model_strap(strap), .req, .req_data, .ack_q,
    .rd_data_q, .busy_q, .mmd_valid_q, .mmd_req_q, .mmd_ack, .mmd_rdata);
  mmdia_mmd_model u_mmd (.mclk, .rstn, .slow, .valid(mmd_valid_q), .req(mmd_req_q),
    .ack(mmd_ack), .rdata(mmd_rdata));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic xfer(input logic [4:0] a, input logic w, input logic [15:0] d);
    int i;
    @(negedge mclk);
    req = 1'b1;
    req_data = '{a, w, d};
    @(negedge mclk);
    req = 1'b0;
    for (i = 0; i < 20 && ack_q !== 1'b1; i++) @(negedge mclk);
    chk({15'h0000, ack_q}, 16'h0001);
    rd = rd_data_q;
  endtask : xfer
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (8) @(negedge mclk);
    rstn = 1'b1;
    foreach (rows[i]) begin
      xfer(rows[i].a, rows[i].w, rows[i].d);
      chk(rd, rows[i].e);
    end
    $display("table test done");
    slow = 1'b1;
    xfer(5'h0d, 1'b1, 16'h8005);
    xfer(5'h0e, 1'b0, 16'h0000);
    chk(rd, 16'h2800);
    xfer(5'h0e, 1'b0, 16'h0000);
    chk(rd, 16'h2801);
    xfer(5'h0e, 1'b1, 16'h5a5a);
    chk(mmd_req_q.wdata, 16'h5a5a);
    chk({15'h0000, mmd_req_q.write}, 16'h0001);
    chk(mmd_req_q.regaddr, 16'h0002);
    chk({11'h000, mmd_req_q.devsel}, 16'h0005);
    xfer(5'h0e, 1'b0, 16'h0000);
    chk(rd, 16'h2803);
    $display("slow mmd test done");
    @(negedge mclk);
    ce = 1'b0;
    req = 1'b1;
    req_data = '{5'h0e, 1'b0, 16'h0000};
    @(negedge mclk);
    req = 1'b0;
    repeat (2) @(negedge mclk);
    chk({15'h0000, ack_q}, 16'h0000);
    chk({15'h0000, busy_q}, 16'h0000);
    ce = 1'b1;
    repeat (2) @(negedge mclk);
    chk({15'h0000, ack_q}, 16'h0000);
    $display("clock enable test done");
    strap = 6'h13;
    xfer(5'h03, 1'b0, 16'h0000);
    chk(rd, 16'h56a5);
    rstn = 1'b0;
    @(negedge mclk);
    rstn = 1'b1;
    xfer(5'h0d, 1'b0, 16'h0000);
    chk(rd, 16'h0000);
    xfer(5'h03, 1'b0, 16'h0000);
    chk(rd, 16'h5535);
    xfer(5'h0d, 1'b1, 16'h0005);
    xfer(5'h0e, 1'b0, 16'h0000);
    chk(rd, 16'h0000);
    $display("reset test done");
    end_of_test();
  end
  initial begin
    #20us;
    $display("wrong value at %0t: watchdog expired", $time);
    miscompares++;
    end_of_test();
  end
endmodule : mmdia_core_tb_top
